// file: core/supol_pkg.sv
package supol_pkg;
  // Register offsets (byte addresses, one 32-bit word each).
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_REF_CFG = 8'h04;
  localparam logic [7:0] ADDR_ALM_CFG = 8'h08;
  localparam logic [7:0] ADDR_ALM_THR = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_BATT_CMD = 8'h1c;
  // Control register fields.
  localparam int CTRL_EXT_TRIP = 0;
  localparam int CTRL_WD_LONG = 1;
  localparam int CTRL_WD_DIS = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Reference output config fields.
  localparam int REF_XTAL_EN = 0;
  localparam int REF_SEC_EN = 1;
  localparam logic [1:0] REF_RESET = 2'h0;
  // Interrupt status bits.
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_BATT_LOW = 1;
  localparam int IRQ_RESET = 2;
  localparam int IRQ_W = 3;
  // Timing, in 32.768 kHz timebase ticks.
  localparam int CLK_HZ = 100000000;
  localparam int TICK_HZ = 32768;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int WD_SHORT_MS = 200;
  localparam int WD_LONG_MS = 1600;
  localparam int WD_SHORT_TICKS = WD_SHORT_MS * TICK_HZ / 1000;
  localparam int WD_LONG_TICKS = WD_LONG_MS * TICK_HZ / 1000;
  localparam int TEST_S = 1;
  localparam int TEST_TICKS = TEST_S * TICK_HZ;
  localparam int RESET_PULSE_TICKS = 6554;
  localparam int MEM_HOLD_TICKS = 33;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } supol_bus_t;
endpackage

// file: core/supol_top.sv
// How it works
// - reference outputs driven only when enabled
// - alarm pin low on time match
// - alarm register access clears alarm pin
// - memory select passes outside reset, and while held after reset onset
// - held select ends on hold or release
// - internal threshold flags low battery by default
// - external threshold flags low battery when selected
// - reset pulses, held during supply/manual low
// - reset stretched after cause goes away
// - watchdog timeout asserts reset, two periods
// - watchdog clears on edges and reset
// - test strobe high one second, external
//
// Strobed register access and the register addresses were chosen for this implementation.
module supol_top
  import supol_pkg::*;
#(
  parameter int RESET_PULSE = RESET_PULSE_TICKS,
  parameter int WD_SHORT = WD_SHORT_TICKS,
  parameter int WD_LONG = WD_LONG_TICKS,
  parameter int TEST_LEN = TEST_TICKS,
  parameter int TICK_CYCLES = TICK_DIV
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire supol_bus_t bus,
  output logic [31:0] rdata,
  // Interrupt.
  output logic irq,
  // Supervisor inputs, asynchronous.
  input wire logic supply_low_in,
  input wire logic manual_reset_in_n,
  input wire logic watchdog_kick_in,
  // Memory chip select.
  input wire logic mem_select_in_n,
  output logic mem_select_out_n,
  // Battery test inputs, asynchronous comparator results.
  input wire logic internal_battery_threshold,
  input wire logic external_threshold_ref,
  // Time match from the calendar, same clock.
  input wire logic time_match,
  // Open-drain pull-down enables.
  output logic reset_pull_n,
  output logic alarm_out_n,
  output logic battery_low_n,
  // Push-pull outputs.
  output logic test_strobe,
  output logic crystal_freq_out,
  output logic seconds_pulse_out
);
  localparam int TW = 24;
  localparam int NSYNC = 6;

  // Three-stage synchronisers; a change counts when stages 2 and 3 agree.
  // Stages reset low, so the manual input reads as active until it is synced.
  // Reset therefore holds until every cause is known.
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, clean_reg;
  assign async_in = {mem_select_in_n, external_threshold_ref, internal_battery_threshold,
                     watchdog_kick_in, manual_reset_in_n, supply_low_in};
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_reg[g] <= 1'b0;
          s2_reg[g] <= 1'b0;
          s3_reg[g] <= 1'b0;
          clean_reg[g] <= 1'b0;
        end else begin
          s1_reg[g] <= async_in[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          if (s2_reg[g] == s3_reg[g]) begin
            clean_reg[g] <= s3_reg[g];
          end
        end
      end
    end
  endgenerate
  wire supply_low = clean_reg[0];
  wire manual_low = ~clean_reg[1];
  wire wd_level = clean_reg[2];
  wire batt_int_low = clean_reg[3];
  wire batt_ext_low = clean_reg[4];
  wire sel_in_n = clean_reg[5];

  // Timebase tick at the oscillator rate.
  // The divider free-runs from reset; all timing below counts its ticks.
  logic [15:0] div_reg;
  logic tick;
  assign tick = (div_reg == 16'(TICK_CYCLES - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
    end
  end

  // Reference waveforms: crystal rate square wave and 1 Hz.
  // Toggle points of the 1 Hz wave, at half and whole second in ticks.
  localparam logic [14:0] SEC_HALF = 15'(TICK_HZ / 2 - 1);
  localparam logic [14:0] SEC_FULL = 15'(TICK_HZ - 1);
  logic xtal_reg;
  logic [14:0] sec_cnt_reg;
  logic sec_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xtal_reg <= 1'b0;
      sec_cnt_reg <= 15'h0000;
      sec_reg <= 1'b0;
    end else begin
      if (div_reg == 16'(TICK_CYCLES / 2 - 1) || tick) begin
        xtal_reg <= ~xtal_reg;
      end
      if (tick) begin
        sec_cnt_reg <= sec_cnt_reg + 15'h0001;
        if (sec_cnt_reg == SEC_HALF || sec_cnt_reg == SEC_FULL) begin
          sec_reg <= ~sec_reg;
        end
      end
    end
  end

  // Register decode.
  // Alarm register accesses of either kind clear the alarm pin.
  wire wr_ctrl = bus.wr && bus.addr == ADDR_CTRL;
  wire wr_ref = bus.wr && bus.addr == ADDR_REF_CFG;
  wire acc_alm_cfg = (bus.wr || bus.rd) && bus.addr == ADDR_ALM_CFG;
  wire acc_alm_thr = (bus.wr || bus.rd) && bus.addr == ADDR_ALM_THR;
  wire rd_irq = bus.rd && bus.addr == ADDR_IRQ_STAT;
  wire wr_mask = bus.wr && bus.addr == ADDR_IRQ_MASK;
  wire wr_alm_cfg = bus.wr && bus.addr == ADDR_ALM_CFG;
  wire wr_alm_thr = bus.wr && bus.addr == ADDR_ALM_THR;
  wire batt_cmd = bus.wr && bus.addr == ADDR_BATT_CMD && bus.wdata[0];

  logic [2:0] ctrl_reg;
  logic [1:0] ref_reg;
  logic [7:0] alm_cfg_reg;
  logic [31:0] alm_thr_reg;
  logic [IRQ_W-1:0] mask_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
      ref_reg <= REF_RESET;
      alm_cfg_reg <= 8'h00;
      alm_thr_reg <= 32'h0000_0000;
      mask_reg <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= bus.wdata[2:0];
      if (wr_ref) ref_reg <= bus.wdata[1:0];
      if (wr_alm_cfg) alm_cfg_reg <= bus.wdata[7:0];
      if (wr_alm_thr) alm_thr_reg <= bus.wdata;
      if (wr_mask) mask_reg <= bus.wdata[IRQ_W-1:0];
    end
  end

  // Reference outputs.
  assign crystal_freq_out = ref_reg[REF_XTAL_EN] & xtal_reg;
  assign seconds_pulse_out = ref_reg[REF_SEC_EN] & sec_reg;

  // Alarm latch: a match in the clearing cycle wins.
  logic alarm_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_reg <= 1'b0;
    end else if (time_match) begin
      alarm_reg <= 1'b1;
    end else if (acc_alm_cfg || acc_alm_thr) begin
      alarm_reg <= 1'b0;
    end
  end
  assign alarm_out_n = ~alarm_reg;

  // Watchdog.
  // Disable keeps the counter at zero, so re-enabling starts a full timeout.
  logic wd_prev_reg;
  logic [TW-1:0] wd_cnt_reg;
  logic wd_fire;
  logic rst_active;
  wire wd_edge = wd_level ^ wd_prev_reg;
  wire [TW-1:0] wd_limit = ctrl_reg[CTRL_WD_LONG] ? TW'(WD_LONG) : TW'(WD_SHORT);
  assign wd_fire = !ctrl_reg[CTRL_WD_DIS] && tick && wd_cnt_reg >= wd_limit - TW'(1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_prev_reg <= 1'b0;
      wd_cnt_reg <= '0;
    end else begin
      wd_prev_reg <= wd_level;
      if (wd_edge || rst_active || ctrl_reg[CTRL_WD_DIS]) begin
        wd_cnt_reg <= '0;
      end else if (tick) begin
        wd_cnt_reg <= wd_cnt_reg + TW'(1);
      end
    end
  end

  // Reset generator: hold while a cause is present, then stretch.
  typedef enum logic [1:0] {RS_IDLE, RS_HOLD, RS_PULSE} supol_rst_t;
  // HOLD is the reset state, so the pin stays low until the synced causes clear.
  supol_rst_t rs_reg;
  logic [TW-1:0] rp_cnt_reg;
  wire cause = supply_low || manual_low;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_reg <= RS_HOLD;
      rp_cnt_reg <= '0;
    end else begin
      case (rs_reg)
        RS_IDLE: begin
          if (cause) begin
            rs_reg <= RS_HOLD;
          end else if (wd_fire) begin
            rs_reg <= RS_PULSE;
            rp_cnt_reg <= '0;
          end
        end
        RS_HOLD: begin
          rp_cnt_reg <= '0;
          if (!cause) rs_reg <= RS_PULSE;
        end
        RS_PULSE: begin
          if (cause) begin
            rs_reg <= RS_HOLD;
          end else if (tick) begin
            if (rp_cnt_reg >= TW'(RESET_PULSE - 1)) begin
              rs_reg <= RS_IDLE;
            end
            rp_cnt_reg <= rp_cnt_reg + TW'(1);
          end
        end
        default: rs_reg <= RS_HOLD;
      endcase
    end
  end
  assign rst_active = (rs_reg != RS_IDLE);
  assign reset_pull_n = ~rst_active;

  // Memory select gating with hold after reset onset.
  logic rst_prev_reg;
  logic hold_reg;
  logic [TW-1:0] hold_cnt_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_prev_reg <= 1'b1;
      hold_reg <= 1'b0;
      hold_cnt_reg <= '0;
    end else begin
      rst_prev_reg <= rst_active;
      if (rst_active && !rst_prev_reg && !sel_in_n) begin
        hold_reg <= 1'b1;
        hold_cnt_reg <= '0;
      end else if (hold_reg) begin
        if (sel_in_n || !rst_active) begin
          hold_reg <= 1'b0;
        end else if (tick) begin
          if (hold_cnt_reg >= TW'(MEM_HOLD_TICKS - 1)) hold_reg <= 1'b0;
          hold_cnt_reg <= hold_cnt_reg + TW'(1);
        end
      end
    end
  end
  wire pass_sel = !sel_in_n && (!rst_active || hold_reg);
  // The onset term covers the cycle before hold_reg is loaded.
  logic sel_out_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_out_reg <= 1'b0;
    end else begin
      sel_out_reg <= pass_sel || (!sel_in_n && rst_active && !rst_prev_reg);
    end
  end
  assign mem_select_out_n = ~sel_out_reg;

  // Battery test: one second window, result sampled at its end.
  // A start request while a test runs is ignored.
  logic [TW-1:0] test_cnt_reg;
  logic testing_reg;
  logic batt_low_reg;
  wire test_done = testing_reg && tick && test_cnt_reg >= TW'(TEST_LEN - 1);
  wire batt_result = ctrl_reg[CTRL_EXT_TRIP] ? batt_ext_low : batt_int_low;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      testing_reg <= 1'b0;
      test_cnt_reg <= '0;
      batt_low_reg <= 1'b0;
    end else begin
      if (batt_cmd && !testing_reg) begin
        testing_reg <= 1'b1;
        test_cnt_reg <= '0;
      end else if (test_done) begin
        testing_reg <= 1'b0;
        batt_low_reg <= batt_result;
      end else if (testing_reg && tick) begin
        test_cnt_reg <= test_cnt_reg + TW'(1);
      end
    end
  end
  assign test_strobe = testing_reg && ctrl_reg[CTRL_EXT_TRIP];
  assign battery_low_n = ~batt_low_reg;

  // Interrupt status: sets win over read-clear.
  // Alarm and reset bits catch onsets only, so a held level sets once.
  logic [IRQ_W-1:0] irq_reg;
  logic [IRQ_W-1:0] irq_set;
  assign irq_set = {rst_active && !rst_prev_reg, test_done && batt_result,
                    time_match && !alarm_reg};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= '0;
    end else begin
      irq_reg <= (rd_irq ? '0 : irq_reg) | irq_set;
    end
  end
  assign irq = |(irq_reg & mask_reg);

  // Read data, one cycle after the strobe.
  // Unmapped addresses read as zero.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (bus.addr)
      ADDR_CTRL: rd_mux = {29'h0, ctrl_reg};
      ADDR_REF_CFG: rd_mux = {30'h0, ref_reg};
      ADDR_ALM_CFG: rd_mux = {24'h0, alm_cfg_reg};
      ADDR_ALM_THR: rd_mux = alm_thr_reg;
      ADDR_STATUS: rd_mux = {27'h0, testing_reg, batt_low_reg, hold_reg, alarm_reg, rst_active};
      ADDR_IRQ_STAT: rd_mux = {29'h0, irq_reg};
      ADDR_IRQ_MASK: rd_mux = {29'h0, mask_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= bus.rd ? rd_mux : 32'h0000_0000;
    end
  end
endmodule

// file: tb/supol_chk_assertions.sv
module supol_chk
  import supol_pkg::*;
(
  // Clock, reset and register port.
  input wire logic clk,
  input wire logic rst_n,
  input wire supol_bus_t bus,
  input wire logic [31:0] rdata,
  input wire logic irq,
  // Supervisor and select pins.
  input wire logic supply_low_in,
  input wire logic manual_reset_in_n,
  input wire logic watchdog_kick_in,
  input wire logic mem_select_in_n,
  input wire logic mem_select_out_n,
  // Battery, alarm and reset pins.
  input wire logic internal_battery_threshold,
  input wire logic external_threshold_ref,
  input wire logic time_match,
  input wire logic reset_pull_n,
  input wire logic alarm_out_n,
  input wire logic battery_low_n,
  // Push-pull outputs.
  input wire logic test_strobe,
  input wire logic crystal_freq_out,
  input wire logic seconds_pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ref_reg;
  logic ext_reg;
  wire alm_addr = (bus.addr == ADDR_ALM_CFG) | (bus.addr == ADDR_ALM_THR);
  wire alm_acc = (bus.wr | bus.rd) & alm_addr;
  // Shadows of the enables, so the outputs can be judged from the bus alone.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_reg <= 2'h0;
      ext_reg <= 1'h0;
    end else if (bus.wr) begin
      if (bus.addr == ADDR_REF_CFG) ref_reg <= bus.wdata[1:0];
      if (bus.addr == ADDR_CTRL) ext_reg <= bus.wdata[CTRL_EXT_TRIP];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_alarm_set: assert property (time_match |=> !alarm_out_n)
    else $error("alarm pin not low after time match");
  chk_alarm_hold: assert property (!alarm_out_n && !alm_acc |=> !alarm_out_n)
    else $error("alarm pin released without access");
  chk_alarm_clear: assert property (alm_acc && !time_match |=> alarm_out_n)
    else $error("alarm pin not cleared by access");
  chk_xtal_off: assert property (!ref_reg[0] && !$past(ref_reg[0]) |-> !crystal_freq_out)
    else $error("crystal output driven while disabled");
  chk_sec_off: assert property (!ref_reg[1] && !$past(ref_reg[1]) |-> !seconds_pulse_out)
    else $error("seconds output driven while disabled");
  chk_strobe_int: assert property (!ext_reg && !$past(ext_reg) |-> !test_strobe)
    else $error("test strobe high with internal trip");
  chk_select_gate: assert property (mem_select_in_n [*8] |-> mem_select_out_n)
    else $error("memory select low while input high");
  chk_manual_hold: assert property (!manual_reset_in_n [*8] |-> !reset_pull_n)
    else $error("reset released during manual reset");
  chk_supply_hold: assert property (supply_low_in [*8] |-> !reset_pull_n)
    else $error("reset released during supply low");
  chk_reset_stretch: assert property ($rose(reset_pull_n) |->
    $past(manual_reset_in_n, 8) && !$past(supply_low_in, 8))
    else $error("reset released too soon after its cause");
endmodule

bind supol_top supol_chk u_chk (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
  .irq(irq), .supply_low_in(supply_low_in), .manual_reset_in_n(manual_reset_in_n),
  .watchdog_kick_in(watchdog_kick_in), .mem_select_in_n(mem_select_in_n),
  .mem_select_out_n(mem_select_out_n), .internal_battery_threshold(internal_battery_threshold),
  .external_threshold_ref(external_threshold_ref), .time_match(time_match),
  .reset_pull_n(reset_pull_n), .alarm_out_n(alarm_out_n), .battery_low_n(battery_low_n),
  .test_strobe(test_strobe), .crystal_freq_out(crystal_freq_out),
  .seconds_pulse_out(seconds_pulse_out));

// file: tb/supol_host_model.sv
module supol_host_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Kick control.
  input wire logic kick_en,
  // Watchdog pin.
  output logic watchdog_kick_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;
  // Toggling every 16 cycles stays well inside the shortest timeout.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      watchdog_kick_in <= 1'h0;
    end else if (kick_en) begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg == 4'hf) watchdog_kick_in <= ~watchdog_kick_in;
    end
  end
endmodule

// file: tb/supol_tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import supol_pkg::*;
  localparam int TK = 4;
  logic clk, rst_n, irq, kick_en, wd;
  supol_bus_t bus;
  logic [31:0] rdata;
  logic sl, mr_n, ms_in_n, ms_out_n, ibt, etr, tm, rp_n, al_n, bl_n, ts, xo, so;
  logic [1:0] seen;
  int failures = 0;
  int samples_checked = 0;
  wire [2:0] mon = {ms_out_n, al_n, rp_n};
  supol_top #(.RESET_PULSE(4), .WD_SHORT(20), .WD_LONG(40), .TEST_LEN(8), .TICK_CYCLES(TK))
    uut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .irq(irq), .supply_low_in(sl),
    .manual_reset_in_n(mr_n), .watchdog_kick_in(wd), .mem_select_in_n(ms_in_n),
    .mem_select_out_n(ms_out_n), .internal_battery_threshold(ibt),
    .external_threshold_ref(etr), .time_match(tm), .reset_pull_n(rp_n), .alarm_out_n(al_n),
    .battery_low_n(bl_n), .test_strobe(ts), .crystal_freq_out(xo), .seconds_pulse_out(so));
  supol_host_model host (.clk(clk), .rst_n(rst_n), .kick_en(kick_en), .watchdog_kick_in(wd));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_pin(input string what, input int i, input logic v, input int lo, hi);
    int n;
    n = 0;
    #1;
    while (mon[i] !== v && n <= hi) begin
      cyc(1);
      n++;
    end
    check(what, 1, n >= lo && n <= hi);
    if (n > hi) report_and_stop();
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 0; bus = '0; sl = 0; mr_n = 1; kick_en = 1; ms_in_n = 1; ibt = 0; etr = 0; tm = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    wait_pin("power-on release", 0, 1, 16, 40);
    check("pins idle", 6'h38, {al_n, bl_n, ms_out_n, ts, xo, so});
    acc(0, ADDR_CTRL, 0);
    check("ctrl reset", CTRL_RESET, rdata);
    acc(0, ADDR_REF_CFG, 0);
    check("ref reset", REF_RESET, rdata);
    acc(0, 8'h20, 0);
    check("unmapped", 0, rdata);
    acc(0, ADDR_IRQ_STAT, 0);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) tm <= 1;
      @(posedge clk) tm <= 0;
      cyc(3);
      check("alarm set", 0, al_n);
      acc(k[0], k[1] ? ADDR_ALM_THR : ADDR_ALM_CFG, 32'h0000_00a5);
      check("alarm cleared", 1, al_n);
    end
    acc(0, ADDR_ALM_THR, 0);
    check("threshold kept", 32'h0000_00a5, rdata);
    check("irq masked", 0, irq);
    acc(1, ADDR_IRQ_MASK, 32'h1);
    check("irq raised", 1, irq);
    acc(0, ADDR_IRQ_STAT, 0);
    check("irq alarm bit", 1, rdata[IRQ_ALARM]);
    check("irq cleared", 0, irq);
    $display("test alarm done");
    acc(1, ADDR_REF_CFG, 32'h1);
    seen = 0;
    repeat (12) begin
      cyc(1);
      seen |= xo ? 2'h2 : 2'h1;
    end
    check("crystal toggles", 3, seen);
    acc(1, ADDR_REF_CFG, 32'h0);
    cyc(2);
    check("refs off", 0, {xo, so});
    $display("test refs done");
    @(posedge clk) ibt <= 1;
    acc(1, ADDR_BATT_CMD, 32'h1);
    cyc(10);
    check("strobe internal", 0, ts);
    cyc(40);
    check("low internal", 0, bl_n);
    acc(1, ADDR_CTRL, 32'h1);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) etr <= k[0];
      acc(1, ADDR_BATT_CMD, 32'h1);
      cyc(6);
      check("strobe start", 1, ts);
      cyc(20);
      check("strobe length", 1, ts);
      cyc(14);
      check("strobe end", 0, ts);
      check("low external", !k[0], bl_n);
    end
    $display("test battery done");
    for (int k = 0; k < 2; k++) begin
      acc(1, ADDR_CTRL, {30'h0, k[0], 1'h0});
      @(posedge clk) kick_en <= 0;
      wait_pin("watchdog fires", 0, 0, (k ? 160 : 80) - 24, (k ? 160 : 80) + 20);
      @(posedge clk) kick_en <= 1;
      wait_pin("watchdog pulse", 0, 1, 12, 30);
    end
    acc(1, ADDR_CTRL, 32'h4);
    @(posedge clk) kick_en <= 0;
    cyc(250);
    check("watchdog off", 1, rp_n);
    @(posedge clk) kick_en <= 1;
    acc(1, ADDR_CTRL, 32'h0);
    acc(0, ADDR_IRQ_STAT, 0);
    check("irq reset and battery", 32'h0000_0006, rdata);
    $display("test watchdog done");
    @(posedge clk) ms_in_n <= 0;
    cyc(8);
    check("select passes", 0, ms_out_n);
    @(posedge clk) mr_n <= 0;
    cyc(30);
    check("select held", 0, ms_out_n);
    check("manual reset", 0, rp_n);
    acc(0, ADDR_STATUS, 0);
    check("status in reset", 32'h0000_000d, rdata);
    @(posedge clk) ms_in_n <= 1;
    wait_pin("hold ends on input", 2, 1, 0, 8);
    @(posedge clk) ms_in_n <= 0;
    cyc(8);
    check("select blocked", 1, ms_out_n);
    @(posedge clk) mr_n <= 1;
    wait_pin("manual stretch", 0, 1, 16, 30);
    cyc(8);
    check("select again", 0, ms_out_n);
    @(posedge clk) sl <= 1;
    wait_pin("hold time", 2, 1, MEM_HOLD_TICKS * TK - 8, MEM_HOLD_TICKS * TK + 18);
    @(posedge clk) sl <= 0;
    wait_pin("supply stretch", 0, 1, 16, 30);
    $display("test supervisor done");
    acc(1, ADDR_REF_CFG, 32'h2);
    check("seconds low first", 0, so);
    for (int n = 0; n < 70000 && so !== 1'b1; n++) cyc(1);
    check("seconds output", 1, {xo, so});
    $display("test seconds done");
    report_and_stop();
  end
endmodule
